// ### core/uie_gate_top.sv
/*
  Device interrupt enable register reached by command codes on a 16-bit
  parallel bus, plus the gated status latch and interrupt output.
  Assumes CMD/WR/RD strobes are one-cycle pulses synchronous to CLOCK,
  and event pins are asynchronous.
*/
// How it works
// (RQ1) one enable bit per source
// (RQ2) disabled event never reaches interrupt pin
// (RQ3) only events after enabling raise pin
// (RQ4) enable gates status latching, not output
// (RQ5) bus reset keeps enable bits
// (RQ6) register is 32 bits, four bytes
// (RQ7) C2 writes, C3 reads the register
// (RQ8) two 16-bit words per transfer
// (RQ9) bits 31..24 reserved, read zero
`timescale 1ns/1ps
`default_nettype none
module uie_gate_top
  import uie_pkg::*;
#(
  parameter int SRC_W_P = uie_pkg::SRC_W
) (
  input  wire logic                       CLOCK,
  input  wire logic                       RESET_N,
  input  wire logic                       CMD_STB,
  input  wire logic [7:0]                 CMD_CODE,
  input  wire logic                       WR_STB,
  input  wire logic                       RD_STB,
  input  wire logic [uie_pkg::WORD_W-1:0] WR_DATA,
  output logic      [uie_pkg::WORD_W-1:0] RD_DATA,
  input  wire logic [SRC_W_P-1:0]         EVENT_PIN,
  input  wire logic                       USB_BUS_RESET,
  input  wire logic [SRC_W_P-1:0]         STATUS_CLR,
  output logic      [SRC_W_P-1:0]         STATUS,
  output logic                            IRQ
);
  import uie_pkg::*;

  // ****************************************
  //  command decode and word sequencing
  // ****************************************
  typedef enum logic [2:0] {
    UIE_IDLE  = 3'b001,
    UIE_WRITE = 3'b010,
    UIE_READ  = 3'b100
  } uie_phase_e;

  uie_phase_e         phase;
  uie_phase_e         next_phase;
  uie_phase_e         cmd_phase;
  logic               word_idx;
  logic               is_wr_cmd;
  logic               is_rd_cmd;
  logic               wr_take;
  logic               rd_take;
  logic               last_word;
  logic               low_load;
  logic               gate_load;
  logic [REG_W-1:0]   device_irq_gate_reg;
  logic [REG_W-1:0]   write_value;
  logic [WORD_W-1:0]  low_hold;
  logic [WORD_W-1:0]  rd_word;
  logic [SRC_W_P-1:0] sync_1;
  logic [SRC_W_P-1:0] sync_2;

  // (RQ7) decode the two codes
  assign is_wr_cmd = CMD_STB && (CMD_CODE == CMD_WR_GATE);
  assign is_rd_cmd = CMD_STB && (CMD_CODE == CMD_RD_GATE);
  // a new command ends a half-done transfer and starts its own
  assign cmd_phase = is_wr_cmd ? UIE_WRITE : (is_rd_cmd ? UIE_READ : UIE_IDLE);
  // a command in the same cycle as a strobe wins
  assign wr_take   = (phase == UIE_WRITE) && WR_STB && !CMD_STB;
  assign rd_take   = (phase == UIE_READ) && RD_STB && !CMD_STB;
  assign last_word = word_idx;
  // (RQ8) a lone first word never reaches the register
  assign low_load  = wr_take && !last_word;
  assign gate_load = wr_take && last_word;
  // (RQ9) reserved bits forced zero
  assign write_value = {WR_DATA, low_hold} & GATE_LIVE;
  // (RQ8) low half first
  assign rd_word = last_word ? device_irq_gate_reg[REG_W-1:WORD_W]
                             : device_irq_gate_reg[WORD_W-1:0];

  // unknown codes leave the machine idle
  always_comb begin
    next_phase = phase;
    unique case (phase)
      UIE_IDLE: begin
        if (CMD_STB) begin
          next_phase = cmd_phase;
        end
      end
      UIE_WRITE: begin
        if (CMD_STB) begin
          next_phase = cmd_phase;
        end else if (gate_load) begin
          next_phase = UIE_IDLE;
        end
      end
      UIE_READ: begin
        if (CMD_STB) begin
          next_phase = cmd_phase;
        end else if (rd_take && last_word) begin
          next_phase = UIE_IDLE;
        end
      end
      default: next_phase = UIE_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      phase <= UIE_IDLE;
    end else begin
      phase <= next_phase;
    end
  end

  // ****************************************
  //  word sequencing
  // ****************************************
  // word counter restarts on every command
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      word_idx <= 1'b0;
    end else if (CMD_STB) begin
      word_idx <= 1'b0;
    end else if (wr_take || rd_take) begin
      word_idx <= ~word_idx;
    end
  end

  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      low_hold <= '0;
    end else if (low_load) begin
      low_hold <= WR_DATA;
    end
  end

  // ****************************************
  //  read path
  // ****************************************
  // word stands until the next taken read strobe
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      RD_DATA <= '0;
    end else if (rd_take) begin
      RD_DATA <= rd_word;
    end
  end

  // ****************************************
  //  enable register
  // ****************************************
  // (RQ5) only device reset clears it; bus reset not used here
  // (RQ6) full 32-bit update on second word
  // reserved byte masked on the way in, so reads give zero
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      device_irq_gate_reg <= GATE_RESET;
    end else if (gate_load) begin
      device_irq_gate_reg <= write_value;
    end
  end

  // ****************************************
  //  event sync and status latch
  // ****************************************
  // events are asynchronous; two stages before the edge detector
  // a pulse shorter than one clock period may be missed
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_1 <= '0;
      sync_2 <= '0;
    end else begin
      sync_1 <= EVENT_PIN;
      sync_2 <= sync_1;
    end
  end

  uie_src_if #(.SRC_W(SRC_W_P)) src_bus ();

  // (RQ1) one gate bit per source
  assign src_bus.gate       = device_irq_gate_reg[SRC_W_P-1:0];
  assign src_bus.event_in   = sync_2;
  assign src_bus.status_clr = STATUS_CLR;

  uie_status_latch #(.SRC_W(SRC_W_P)) u_latch (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .src   (src_bus)
  );

  // ****************************************
  //  status and interrupt outputs
  // ****************************************
  // (RQ2) pin follows gated status only
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      STATUS <= '0;
    end else begin
      STATUS <= src_bus.status;
    end
  end

  // both registered, so the pin never leads the status it reports
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |src_bus.status;
    end
  end

  // bus reset event itself enters via EVENT_PIN bit 0; this pin is informational
  wire unused_bus_reset = USB_BUS_RESET;
endmodule
`default_nettype wire

// ### common/uie_pkg.sv
/*
  Constants for the device interrupt enable block: command codes,
  register layout, reset value and source bit positions.
  Assumes a 16-bit parallel command/data bus on the controller clock.
*/
package uie_pkg;
  localparam int          REG_W        = 32;
  localparam int          WORD_W       = 16;
  localparam int          SRC_W        = 24;
  localparam logic [7:0]  CMD_WR_GATE  = 8'hC2;
  localparam logic [7:0]  CMD_RD_GATE  = 8'hC3;
  localparam logic [31:0] GATE_RESET   = 32'h0000_0000;
  localparam logic [31:0] GATE_LIVE    = 32'h00FF_FFFF;
  localparam int          BIT_BUS_RST  = 0;
  localparam int          BIT_SOF      = 1;
  localparam int          BIT_SOF_LOST = 2;
  localparam int          BIT_EOT      = 3;
  localparam int          BIT_SUSPEND  = 4;
  localparam int          BIT_RESUME   = 5;
  localparam int          BIT_EP_FIRST = 8;
  localparam int          WORDS_PER_XFER = 2;
endpackage

// ### common/uie_src_if.sv
/*
  Carrier between the enable register file and the status latch.
  Assumes one clock domain for both modules.
*/
`timescale 1ns/1ps
`default_nettype none
interface uie_src_if #(parameter int SRC_W = 24);
  logic [SRC_W-1:0] gate;
  logic [SRC_W-1:0] event_in;
  logic [SRC_W-1:0] status_clr;
  logic [SRC_W-1:0] status;
  modport ctrl (output gate, output event_in, output status_clr, input status);
  modport latch (input gate, input event_in, input status_clr, output status);
endinterface
`default_nettype wire

// ### core/uie_status_latch.sv
/*
  Interrupt status latch: one sticky bit per source, set only on a new
  event edge while its enable bit is set.
  Assumes event inputs already synchronised to CLOCK.
*/
`timescale 1ns/1ps
`default_nettype none
module uie_status_latch #(
  parameter int SRC_W = 24
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  uie_src_if.latch   src
);
  logic [SRC_W-1:0] event_prev;
  logic [SRC_W-1:0] event_rise;
  logic [SRC_W-1:0] status;
  logic [SRC_W-1:0] next_status;

  // (RQ3) edge only, late enable
  assign event_rise = src.event_in & ~event_prev;
  // (RQ4) gate the latching; set beats clear
  assign next_status = (status & ~src.status_clr) | (event_rise & src.gate);
  assign src.status  = status;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_prev <= '0;
      status     <= '0;
    end else begin
      event_prev <= src.event_in;
      status     <= next_status;
    end
  end
endmodule
`default_nettype wire

// ### verif/uie_gate_monitor.sv
/* Port checker for uie_gate_top.
   Assumes it is bound onto the top module. */
`timescale 1ns/1ps
`default_nettype none
module uie_gate_monitor #(parameter int SRC_W_P = 24) (
  input wire logic               CLOCK,
  input wire logic               RESET_N,
  input wire logic               CMD_STB,
  input wire logic [7:0]         CMD_CODE,
  input wire logic               WR_STB,
  input wire logic               RD_STB,
  input wire logic [15:0]        WR_DATA,
  input wire logic [15:0]        RD_DATA,
  input wire logic [SRC_W_P-1:0] EVENT_PIN,
  input wire logic               USB_BUS_RESET,
  input wire logic [SRC_W_P-1:0] STATUS_CLR,
  input wire logic [SRC_W_P-1:0] STATUS,
  input wire logic               IRQ
);
  import uie_pkg::*;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);
  // ****
  // port relations
  // ****
  AST_IRQ: assert property (IRQ == (STATUS != '0))
    else $error("irq");
  AST_SET: assert property ((STATUS & ~$past(STATUS) & ~$past(EVENT_PIN, 4)) == '0)
    else $error("set");
  AST_KEEP: assert property (($past(STATUS) & ~$past(STATUS_CLR)
    & ~$past(STATUS_CLR, 2) & ~STATUS) == '0) else $error("keep");
  AST_RST: assert property ($rose(RESET_N) |-> STATUS == '0 && !IRQ)
    else $error("rst");
  AST_LO: assert property (CMD_STB && CMD_CODE == CMD_WR_GATE ##1 WR_STB [*2]
    ##1 CMD_STB && CMD_CODE == CMD_RD_GATE ##1 RD_STB
    |=> RD_DATA == $past(WR_DATA, 4)) else $error("lo");
  AST_HI: assert property (CMD_STB && CMD_CODE == CMD_WR_GATE ##1 WR_STB [*2]
    ##1 CMD_STB && CMD_CODE == CMD_RD_GATE ##1 RD_STB [*2]
    |=> RD_DATA == ($past(WR_DATA, 4) & 16'h00FF)) else $error("hi");
  AST_HOLD: assert property (!RD_STB |=> $stable(RD_DATA))
    else $error("hold");
  AST_CODE: assert property (CMD_STB && CMD_CODE != CMD_RD_GATE ##1 RD_STB
    |=> $stable(RD_DATA)) else $error("code");
endmodule
bind uie_gate_top uie_gate_monitor #(.SRC_W_P(SRC_W_P)) u_mon (.CLOCK(CLOCK),
  .RESET_N(RESET_N), .CMD_STB(CMD_STB), .CMD_CODE(CMD_CODE), .WR_STB(WR_STB),
  .RD_STB(RD_STB), .WR_DATA(WR_DATA), .RD_DATA(RD_DATA), .EVENT_PIN(EVENT_PIN),
  .USB_BUS_RESET(USB_BUS_RESET), .STATUS_CLR(STATUS_CLR), .STATUS(STATUS), .IRQ(IRQ));
`default_nettype wire

// ### verif/uie_host_model.sv
/* Host processor model on the command/data bus.
   Assumes the design samples the bus on the rising clock edge. */
`timescale 1ns/1ps
`default_nettype none
module uie_host_model (
  input  wire logic        clk,
  input  wire logic [15:0] rd_data,
  output var  logic        cmd_stb,
  output var  logic [7:0]  cmd_code,
  output var  logic        wr_stb,
  output var  logic        rd_stb,
  output var  logic [15:0] wr_data
);
  import uie_pkg::*;
  initial {cmd_stb, cmd_code, wr_stb, rd_stb, wr_data} = '0;
  // ****
  // bus cycles
  // ****
  // code then words
  task automatic wr(input logic [31:0] v);
    @(negedge clk) {cmd_stb, cmd_code} = {1'b1, CMD_WR_GATE};
    @(negedge clk) {cmd_stb, wr_stb, wr_data} = {2'b01, v[15:0]};
    @(negedge clk) wr_data = v[31:16];
  endtask
  // one word, then stop: no update
  task automatic wr_cut(input logic [15:0] w);
    @(negedge clk) {cmd_stb, cmd_code} = {1'b1, CMD_WR_GATE};
    @(negedge clk) {cmd_stb, wr_stb, wr_data} = {2'b01, w};
    @(negedge clk) wr_stb = 1'b0;
  endtask
  task automatic rd(input logic [7:0] code, output logic [31:0] v);
    @(negedge clk) {cmd_stb, cmd_code, wr_stb, wr_data} = {1'b1, code, 1'b0, ~wr_data};
    @(negedge clk) {cmd_stb, rd_stb} = 2'b01;
    @(negedge clk) v[15:0] = rd_data;
    @(negedge clk) {rd_stb, v[31:16]} = {1'b0, rd_data};
  endtask
endmodule
`default_nettype wire

// ### verif/uie_gate_top_tb.sv
/* Self-checking bench for uie_gate_top.
   Assumes package, host model and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module uie_gate_top_tb;
  import uie_pkg::*;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        usb_bus_reset = 1'b0;
  logic        cmd_stb, wr_stb, rd_stb, irq;
  logic [7:0]  cmd_code;
  logic [15:0] wr_data, rd_data;
  logic [23:0] event_pin = '0, status_clr = '0, status;
  logic [31:0] gate, got;
  int          error_cnt = 0, checked = 0;
  always #4 clock = ~clock;
  uie_host_model u_host (.clk(clock), .rd_data(rd_data), .cmd_stb(cmd_stb),
    .cmd_code(cmd_code), .wr_stb(wr_stb), .rd_stb(rd_stb), .wr_data(wr_data));
  uie_gate_top u_dut (.CLOCK(clock), .RESET_N(reset_n), .CMD_STB(cmd_stb),
    .CMD_CODE(cmd_code), .WR_STB(wr_stb), .RD_STB(rd_stb), .WR_DATA(wr_data),
    .RD_DATA(rd_data), .EVENT_PIN(event_pin), .USB_BUS_RESET(usb_bus_reset),
    .STATUS_CLR(status_clr), .STATUS(status), .IRQ(irq));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] expect_gate(input logic [31:0] v);
    return v & GATE_LIVE;
  endfunction
  task automatic put(input logic [31:0] v);
    u_host.wr(v);
    gate = expect_gate(v);
    u_host.rd(CMD_RD_GATE, got);
    chk(got, gate);
  endtask
  // events held long, then cleared
  task automatic fire(input logic [23:0] ev);
    @(negedge clock) event_pin = ev;
    repeat (8) @(negedge clock);
    chk({7'h0, irq, status}, {7'h0, |(ev & gate[23:0]), ev & gate[23:0]});
    {event_pin, status_clr} = {24'h0, 24'hFFFFFF};
    repeat (2) @(negedge clock);
    status_clr = '0;
    chk({8'h0, status}, 32'h0);
  endtask
  task automatic conclude();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    void'($urandom(32'hB9DF));
    repeat (12) @(negedge clock);
    reset_n = 1'b1;
    u_host.rd(CMD_RD_GATE, got);
    chk(got, GATE_RESET);
    put(32'hFFFF_FFFF);
    fire(24'hFFFFFF);
    for (int i = 0; i < 6; i++) begin
      put($urandom);
      fire(24'($urandom));
    end
    u_host.wr_cut(~gate[15:0]);
    u_host.rd(CMD_RD_GATE, got);
    chk(got, gate);
    @(negedge clock) usb_bus_reset = 1'b1;
    @(negedge clock) usb_bus_reset = 1'b0;
    u_host.rd(CMD_RD_GATE, got);
    chk(got, gate);
    u_host.rd(8'hC0, got);
    chk(got, {2{gate[31:16]}});
    // device reset in mid-run returns the register to its reset value
    @(negedge clock) reset_n = 1'b0;
    repeat (2) @(negedge clock);
    reset_n = 1'b1;
    chk({7'h0, irq, status}, 32'h0);
    u_host.rd(CMD_RD_GATE, got);
    chk(got, GATE_RESET);
    put(32'h0);
    @(negedge clock) event_pin = 24'hFFFFFF;
    repeat (8) @(negedge clock);
    chk({7'h0, irq, status}, 32'h0);
    put(32'hFFFFFF);
    repeat (8) @(negedge clock);
    chk({8'h0, status}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
